// *** dv/sfpp_properties.sv ***
// checker: link-level properties of the serial flash program port
`default_nettype none
module sfpp_properties (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic master_clear_pin_hv,
   input wire logic h_dat_o,
   input wire logic h_dat_oe,
   input wire logic d_dat_o,
   input wire logic d_dat_oe,
   input wire logic dat
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////
   // a low span this long ends a command or a frame; in-frame lows are far shorter
   localparam logic [7:0] GAP = 8'h1E;
   logic [7:0] low_q;
   logic [4:0] rise_q;
   logic [4:0] fall_q;
   logic sck_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         low_q <= 8'h00;
         rise_q <= 5'h00;
         fall_q <= 5'h00;
         sck_q <= 1'b0;
      end else begin
         sck_q <= sck;
         low_q <= sck ? 8'h00 : ((low_q == 8'hFF) ? low_q : low_q + 8'h01);
         if (low_q == GAP) begin
            rise_q <= 5'h00;
            fall_q <= 5'h00;
         end else begin
            rise_q <= rise_q + 5'(sck && !sck_q);
            fall_q <= fall_q + 5'(!sck && sck_q);
         end
      end
   end
   ////////////////////////////////////////////////////////////
   property p_one_driver;
      !(h_dat_oe && d_dat_oe);
   endproperty
   a_one_driver: assert property (p_one_driver) else $error("both ends drive data");
   property p_dev_needs_mode;
      d_dat_oe |-> master_clear_pin_hv;
   endproperty
   a_dev_needs_mode: assert property (p_dev_needs_mode) else $error("device drives outside mode");
   property p_idle_low;
      !master_clear_pin_hv |-> !sck;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("clock moves outside mode");
   property p_entry_quiet;
      $rose(master_clear_pin_hv) |-> (!sck && !dat)[*8];
   endproperty
   a_entry_quiet: assert property (p_entry_quiet) else $error("clock or data not low at entry");
   property p_sck_high;
      $rose(sck) |-> sck[*8];
   endproperty
   a_sck_high: assert property (p_sck_high) else $error("link clock high phase too short");
   property p_host_hold;
      $fell(sck) && h_dat_oe |-> ($stable(h_dat_o) || !h_dat_oe)[*8];
   endproperty
   a_host_hold: assert property (p_host_hold) else $error("host data moved near falling edge");
   property p_dev_on_rise;
      d_dat_oe && $past(d_dat_oe) && $changed(d_dat_o) |-> sck;
   endproperty
   a_dev_on_rise: assert property (p_dev_on_rise) else $error("device data moved while clock low");
   property p_burst_len;
      low_q == GAP && fall_q != 5'h00 |-> fall_q == 5'h06 || fall_q == 5'h10;
   endproperty
   a_burst_len: assert property (p_burst_len) else $error("burst is neither 6 nor 16 clocks");
   property p_read_start;
      $rose(d_dat_oe) |-> rise_q == 5'h02 && sck;
   endproperty
   a_read_start: assert property (p_read_start) else $error("read drive not at second rise");
   property p_read_stop;
      $fell(d_dat_oe) |-> rise_q == 5'h10 && sck;
   endproperty
   a_read_stop: assert property (p_read_stop) else $error("read release not at sixteenth rise");
   property p_read_top;
      $fell(sck) && d_dat_oe && (rise_q == 5'h0E || rise_q == 5'h0F) |-> d_dat_o;
   endproperty
   a_read_top: assert property (p_read_top) else $error("top read bits not one");
   c_entry: cover property ($rose(master_clear_pin_hv));
   c_read: cover property ($rose(d_dat_oe));
   c_frame: cover property (low_q == GAP && fall_q == 5'h10);
   c_cmd_only: cover property (low_q == GAP && fall_q == 5'h06);
endmodule // sfpp_properties
`default_nettype wire

// *** dv/testbench.sv ***
// testbench: programmer and device joined over the link, run through the command port
`default_nettype none
`include "sfpp_defs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import sfpp_pkg::*;
   logic clk, rst_n, mode_en, cmd_valid;
   logic [3:0] cmd_code;
   logic [11:0] cmd_wdata;
   logic link_idle, cmd_ready, rsp_valid, in_prog_mode, core_rst_n, io_hiz, prog_busy, code_protect;
   logic [11:0] rsp_data, config_word, rd;
   logic [15:0] user_id;
   logic [3:0] bad_codes [10] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h7, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF};
   int mismatches = 0;
   int checked = 0;
   sfpp_if lnk_if ();
   // short end and erase waits keep the run small
   sfpp_prog #(.HALF_CYC(10), .T_END_CYC(200), .T_ERA_CYC(300)) sfpp_prog_inst (.clk(clk), .rst_n(rst_n),
      .lnk(lnk_if.prog), .mode_en(mode_en), .link_idle(link_idle), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   sfpp_dev sfpp_dev_inst (.clk(clk), .rst_n(rst_n), .lnk(lnk_if.dev), .in_prog_mode(in_prog_mode),
      .core_rst_n(core_rst_n), .io_hiz(io_hiz), .prog_busy(prog_busy), .code_protect(code_protect),
      .user_id(user_id), .config_word(config_word));
   sfpp_properties sfpp_properties_inst (.clk(clk), .rst_n(rst_n), .sck(lnk_if.sck), .master_clear_pin_hv(lnk_if.master_clear_pin_hv),
      .h_dat_o(lnk_if.h_dat_o), .h_dat_oe(lnk_if.h_dat_oe), .d_dat_o(lnk_if.d_dat_o),
      .d_dat_oe(lnk_if.d_dat_oe), .dat(lnk_if.dat));
   ////////////////////////////////////////////////////////////
   always #5 clk = ~clk;
   task automatic tally_and_finish();
      if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // request held until the edge that samples ready; read word caught on its one-cycle pulse
   task automatic op(input logic [3:0] code, input logic [11:0] wd);
      logic rdy;
      int n;
      rd = 12'h000;
      n = 0;
      @(posedge clk);
      cmd_code <= code;
      cmd_wdata <= wd;
      cmd_valid <= 1'b1;
      do begin
         @(negedge clk);
         rdy = cmd_ready;
         n++;
         @(posedge clk);
      end while (rdy !== 1'b1 && n < 5000);
      cmd_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         if (rsp_valid === 1'b1) rd = rsp_data;
         n++;
      end while (link_idle !== 1'b1 && n < 5000);
      if (n >= 5000) chk("command completion", 16'h0001, 16'h0000);
   endtask
   task automatic rd_chk(input string what, input logic [11:0] exp);
      op(`SFPP_C_READ, 12'h000);
      chk(what, 16'(exp), 16'(rd));
   endtask
   task automatic write_word(input logic [11:0] wd);
      op(`SFPP_C_LOAD, wd);
      op(`SFPP_C_BEGIN, 12'h000);
      chk("busy after begin", 16'h0001, 16'(prog_busy));
      op(`SFPP_C_END, 12'h000);
      chk("busy after end", 16'h0000, 16'(prog_busy));
   endtask
   task automatic set_mode(input logic en);
      int n;
      n = 0;
      @(posedge clk);
      mode_en <= en;
      do begin
         @(negedge clk);
         n++;
      end while ((en ? link_idle : !in_prog_mode) !== 1'b1 && n < 3000);
      chk("mode change", 16'(en), 16'(in_prog_mode));
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (80000) @(posedge clk);
      chk("watchdog", 16'h0000, 16'h0001);
      tally_and_finish();
   end
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      mode_en = 1'b0;
      cmd_valid = 1'b0;
      cmd_code = 4'h0;
      cmd_wdata = 12'h000;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      set_mode(1'b1);
      chk("core reset", 16'h0000, 16'(core_rst_n));
      chk("io float", 16'h0001, 16'(io_hiz));
      chk("blank user id", 16'hFFFF, user_id);
      chk("blank config", 16'h0FFF, 16'(config_word));
      rd_chk("config at entry", 12'hFFF);
      write_word(12'hDBF);
      chk("config written", 16'h0DBF, 16'(config_word));
      chk("unprotected", 16'h0000, 16'(code_protect));
      foreach (bad_codes[i]) op(bad_codes[i], 12'h000);
      rd_chk("config after bad codes", 12'hDBF);
      op(`SFPP_C_INC, 12'h000);
      rd_chk("word 1 blank", 12'hFFF);
      write_word(12'h5A3);
      rd_chk("word 1 written", 12'h5A3);
      set_mode(1'b0);
      chk("core released", 16'h0001, 16'(core_rst_n));
      chk("io released", 16'h0000, 16'(io_hiz));
      set_mode(1'b1);
      rd_chk("config after reentry", 12'hDBF);
      write_word(12'h93F);
      chk("protected", 16'h0001, 16'(code_protect));
      for (int i = 1; i <= 3; i++) begin
         op(`SFPP_C_ERASE, 12'h000);
         chk("protect after erase", 16'(i < 3), 16'(code_protect));
         chk("config after erase", (i < 3) ? 16'h093F : 16'h0FFF, 16'(config_word));
      end
      op(`SFPP_C_INC, 12'h000);
      rd_chk("word 1 erased", 12'hFFF);
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire

// *** src/sfpp_defs.svh ***
// constants of the serial flash program port
// What this block does
// - mode exposes addresses 0x000 through 0x7FF
// - data flash 600h-63Fh takes same commands
// - IDs, trims, reserved, config word at top
// - 12-bit IDs; low nibbles form identifier
// - config word only before first increment
// - trims erased only from configuration region
// - LSb first; change on rise, sample fall
// - entry resets core, floats I/O, clears address
// - programmer holds clock, data low, then raises
// - exit by dropping master clear voltage
// - command is six clocks, LSb first
// - gap, then sixteen-clock data frame
// - read drives rise two, releases rise sixteen
// - load takes bit0 fall two, keeps twelve
// - programmer gaps; longer after end programming
// - six command codes on low nibble
// - increment advances the address by one
// - load before begin; begin writes word
// - end programming stops current write
// - bulk erase scope depends on address
// - protection holds until three bulk erases
// - bulk erase clears reset vector trim
// - programmer waits full erase time
`ifndef SFPP_DEFS_SVH
`define SFPP_DEFS_SVH
`define SFPP_ADDR_W 11
`define SFPP_WORD_W 12
`define SFPP_MEM_WORDS 2048
`define SFPP_ADDR_MIN 11'h000
`define SFPP_ADDR_MAX 11'h7FF
`define SFPP_DATA_LO 11'h600
`define SFPP_CFG_LO 11'h640
`define SFPP_TRIM_LO 11'h644
`define SFPP_RSVD_LO 11'h648
`define SFPP_CFG_WORD 11'h7FF
`define SFPP_RST_VEC 11'h3FF
`define SFPP_ERASED 12'hFFF
`define SFPP_DATA_FLASH_PROTECT_BIT_BIT 6
`define SFPP_CP_MSB 10
`define SFPP_CP_LSB 7
`define SFPP_CP_ON 4'h2
`define SFPP_ERASE_PASSES 2'h3
`define SFPP_CMD_BITS 5'h06
`define SFPP_FRAME_BITS 5'h10
`define SFPP_DATA_BITS 14
`define SFPP_C_LOAD 4'h2
`define SFPP_C_READ 4'h4
`define SFPP_C_INC 4'h6
`define SFPP_C_BEGIN 4'h8
`define SFPP_C_END 4'hE
`define SFPP_C_ERASE 4'h9
`define SFPP_CLK_NS 10
`define SFPP_CYC_UP(ns) (((ns) + `SFPP_CLK_NS - 1) / `SFPP_CLK_NS)
`define SFPP_T_SET_NS 100
`define SFPP_T_DLY_NS 1000
`define SFPP_T_HOLD_NS 5000
`define SFPP_T_END_NS 100000
`define SFPP_T_ERA_NS 10000000
`define SFPP_T_SET_CYC `SFPP_CYC_UP(`SFPP_T_SET_NS)
`define SFPP_T_DLY_CYC `SFPP_CYC_UP(`SFPP_T_DLY_NS)
`define SFPP_T_HOLD_CYC `SFPP_CYC_UP(`SFPP_T_HOLD_NS)
`define SFPP_T_END_CYC `SFPP_CYC_UP(`SFPP_T_END_NS)
`define SFPP_T_ERA_CYC `SFPP_CYC_UP(`SFPP_T_ERA_NS)
`endif

// *** src/sfpp_dev.sv ***
// device end: serial command decoder, address counter and flash array
`default_nettype none
`include "sfpp_defs.svh"
module sfpp_dev (
   input wire logic clk,
   input wire logic rst_n,
   sfpp_if.dev lnk,
   output logic in_prog_mode,
   output logic core_rst_n,
   output logic io_hiz,
   output logic prog_busy,
   output logic code_protect,
   output logic [15:0] user_id,
   output logic [`SFPP_WORD_W-1:0] config_word
);
   import sfpp_pkg::*;

   ////////////////////////////////////////////////////////////////
   logic [`SFPP_WORD_W-1:0] mem [0:`SFPP_MEM_WORDS-1];
   sfpp_dev_s q, n;
   logic [2:0] pin_s;
   logic [2:0] pin_p;
   logic ck_rise, ck_fall, dat_s, hv_s;
   logic [`SFPP_ADDR_W-1:0] tgt;
   logic acc_ok, prot, data_flash_protect_bit;
   logic [`SFPP_WORD_W-1:0] rd_word;
   logic wr_en, er_user, er_data, er_cfgw, er_id, er_trim;
   logic [5:0] cmd_w;
   sfpp_region_e rg;

   function automatic sfpp_region_e region_of(input logic [`SFPP_ADDR_W-1:0] a);
      if (a < `SFPP_DATA_LO) begin
         return RG_USER;
      end else if (a < `SFPP_CFG_LO) begin
         return RG_DATA;
      end
      return RG_CFG;
   endfunction

   // clock pin is only sampled; its edges are found here
   sfpp_sync #(.W(3)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({lnk.master_clear_pin_hv, lnk.dat, lnk.sck}),
      .q(pin_s),
      .q_prev(pin_p)
   );
   assign ck_rise = pin_s[0] & ~pin_p[0];
   assign ck_fall = ~pin_s[0] & pin_p[0];
   assign dat_s = pin_s[1];
   assign hv_s = pin_s[2];

   ////////////////////////////////////////////////////////////////
   // the config word hides behind the counter until the first increment
   assign tgt = q.cfg_ok ? `SFPP_CFG_WORD : q.addr;
   assign acc_ok = q.cfg_ok || (q.addr != `SFPP_CFG_WORD);
   assign rg = region_of(tgt);
   assign rd_word = acc_ok ? mem[tgt] : `SFPP_ERASED;
   assign data_flash_protect_bit = q.cfg[`SFPP_DATA_FLASH_PROTECT_BIT_BIT];
   assign prot = (q.cfg[`SFPP_CP_MSB:`SFPP_CP_LSB] == `SFPP_CP_ON) && (q.erases != `SFPP_ERASE_PASSES);

   always_comb begin
      n = q;
      cmd_w = {dat_s, q.cmd[5:1]};
      wr_en = 1'b0;
      er_user = 1'b0;
      er_data = 1'b0;
      er_cfgw = 1'b0;
      er_id = 1'b0;
      er_trim = 1'b0;
      if (!hv_s) begin
         n = '0;
      end else if (!q.in_mode) begin
         n = '0;
         n.in_mode = 1'b1;
         n.cfg_ok = 1'b1;
      end else begin
         case (q.st)
            D_CMD: begin
               if (ck_fall) begin
                  n.cmd = cmd_w;
                  n.fcnt = q.fcnt + 5'h01;
                  if (q.fcnt == `SFPP_CMD_BITS - 5'h01) begin
                     n.fcnt = 5'h00;
                     case (cmd_w[3:0])
                        `SFPP_C_LOAD: begin
                           n.st = D_LOAD;
                        end
                        `SFPP_C_READ: begin
                           n.st = D_READ;
                           n.rcnt = 5'h00;
                           n.sh = {2'b11, rd_word};
                        end
                        `SFPP_C_INC: begin
                           n.addr = q.addr + 11'h001;
                           n.cfg_ok = 1'b0;
                        end
                        `SFPP_C_BEGIN: begin
                           // protected user code is not rewritten
                           wr_en = acc_ok && !(prot && rg == RG_USER);
                           n.busy = 1'b1;
                        end
                        `SFPP_C_END: begin
                           n.busy = 1'b0;
                        end
                        `SFPP_C_ERASE: begin
                           if (q.cfg_ok || rg == RG_USER) begin
                              // config word, which holds the protection, goes on every pass when unprotected, on the last pass only when protected
                              er_cfgw = !prot || (q.erases == `SFPP_ERASE_PASSES - 2'h1);
                              er_user = 1'b1;
                              er_data = !data_flash_protect_bit;
                           end else if (rg == RG_DATA) begin
                              er_data = data_flash_protect_bit;
                           end else begin
                              er_id = 1'b1;
                              er_trim = 1'b1;
                           end
                           if (q.erases != `SFPP_ERASE_PASSES) begin
                              n.erases = q.erases + 2'h1;
                           end
                        end
                        default: begin
                        end
                     endcase
                  end
               end
            end
            D_LOAD: begin
               if (ck_fall) begin
                  n.fcnt = q.fcnt + 5'h01;
                  if (q.fcnt != 5'h00 && q.fcnt < `SFPP_FRAME_BITS - 5'h01) begin
                     n.sh = {dat_s, q.sh[`SFPP_DATA_BITS-1:1]};
                  end
                  if (q.fcnt == `SFPP_FRAME_BITS - 5'h01) begin
                     n.ld = q.sh[`SFPP_WORD_W-1:0];
                     n.fcnt = 5'h00;
                     n.st = D_CMD;
                  end
               end
            end
            D_READ: begin
               if (ck_rise) begin
                  n.rcnt = q.rcnt + 5'h01;
                  if (q.rcnt != 5'h00 && q.rcnt < `SFPP_FRAME_BITS - 5'h01) begin
                     n.dat_oe = 1'b1;
                     n.dat_o = q.sh[0];
                     n.sh = {1'b1, q.sh[`SFPP_DATA_BITS-1:1]};
                  end else begin
                     n.dat_oe = 1'b0;
                  end
               end
               if (ck_fall) begin
                  n.fcnt = q.fcnt + 5'h01;
                  if (q.fcnt == `SFPP_FRAME_BITS - 5'h01) begin
                     n.fcnt = 5'h00;
                     n.dat_oe = 1'b0;
                     n.st = D_CMD;
                  end
               end
            end
            default: begin
               n.st = D_CMD;
            end
         endcase
      end
      n.cfg = mem[`SFPP_CFG_WORD];
      // first ID word lands in the top nibble
      n.uid = {mem[`SFPP_CFG_LO][3:0], mem[`SFPP_CFG_LO + 1][3:0],
               mem[`SFPP_CFG_LO + 2][3:0], mem[`SFPP_CFG_LO + 3][3:0]};
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////
   // selected-region erase in one cycle; reset leaves a blank part for simulation
   always_ff @(posedge clk) begin
      for (int i = 0; i < `SFPP_MEM_WORDS; i++) begin
         if (!rst_n
             || (er_user && i < `SFPP_DATA_LO)
             || (er_data && i >= `SFPP_DATA_LO && i < `SFPP_CFG_LO)
             || (er_id && i >= `SFPP_CFG_LO && i < `SFPP_TRIM_LO)
             || (er_trim && i >= `SFPP_TRIM_LO && i < `SFPP_RSVD_LO)
             || (er_cfgw && i == `SFPP_CFG_WORD)) begin
            mem[i] <= `SFPP_ERASED;
         end
      end
      if (rst_n && wr_en) begin
         mem[tgt] <= q.ld;
      end
   end

   assign lnk.d_dat_o = q.dat_o;
   assign lnk.d_dat_oe = q.dat_oe;
   assign in_prog_mode = q.in_mode;
   assign core_rst_n = ~q.in_mode;
   assign io_hiz = q.in_mode;
   assign prog_busy = q.busy;
   assign code_protect = prot;
   assign user_id = q.uid;
   assign config_word = q.cfg;
endmodule // sfpp_dev
`default_nettype wire

// *** src/sfpp_if.sv ***
// link between programmer and device: clock, master clear, shared data pin
`default_nettype none
interface sfpp_if;
   logic sck;
   logic master_clear_pin_hv;
   logic h_dat_o;
   logic h_dat_oe;
   logic d_dat_o;
   logic d_dat_oe;
   logic dat;
   // pulled low when nobody drives
   assign dat = h_dat_oe ? h_dat_o : (d_dat_oe ? d_dat_o : 1'b0);
   modport dev (input sck, input master_clear_pin_hv, input dat, output d_dat_o, output d_dat_oe);
   modport prog (output sck, output master_clear_pin_hv, output h_dat_o, output h_dat_oe, input dat);
endinterface
`default_nettype wire

// *** src/sfpp_pkg.sv ***
// types of the serial flash program port
`default_nettype none
`include "sfpp_defs.svh"
package sfpp_pkg;
   typedef enum logic [1:0] {D_CMD, D_LOAD, D_READ} sfpp_dev_st_e;
   typedef enum logic [1:0] {RG_USER, RG_DATA, RG_CFG} sfpp_region_e;
   typedef enum logic [2:0] {H_OFF, H_HOLD, H_IDLE, H_CMD, H_GAP, H_DATA, H_WAIT} sfpp_host_st_e;
   typedef struct packed {
      sfpp_dev_st_e st;
      logic in_mode;
      logic cfg_ok;
      logic [`SFPP_ADDR_W-1:0] addr;
      logic [4:0] fcnt;
      logic [4:0] rcnt;
      logic [5:0] cmd;
      logic [`SFPP_DATA_BITS-1:0] sh;
      logic [`SFPP_WORD_W-1:0] ld;
      logic dat_o;
      logic dat_oe;
      logic busy;
      logic [1:0] erases;
      logic [`SFPP_WORD_W-1:0] cfg;
      logic [15:0] uid;
   } sfpp_dev_s;
   typedef struct packed {
      sfpp_host_st_e st;
      logic master_clear_pin;
      logic sck;
      logic dat_o;
      logic dat_oe;
      logic [4:0] bitn;
      logic [23:0] cnt;
      logic [15:0] sh;
      logic [3:0] cmd;
      logic [`SFPP_WORD_W-1:0] wd;
      logic [`SFPP_DATA_BITS-1:0] rd;
      logic rsp_valid;
      logic [`SFPP_WORD_W-1:0] rsp_data;
   } sfpp_host_s;
endpackage
`default_nettype wire

// *** src/sfpp_prog.sv ***
// programmer end: mode entry, command and frame shifter, inter-command gaps
`default_nettype none
`include "sfpp_defs.svh"
module sfpp_prog #(
   parameter int unsigned HALF_CYC = `SFPP_T_SET_CYC,
   parameter int unsigned T_END_CYC = `SFPP_T_END_CYC,
   parameter int unsigned T_ERA_CYC = `SFPP_T_ERA_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   sfpp_if.prog lnk,
   input wire logic mode_en,
   output logic link_idle,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [3:0] cmd_code,
   input wire logic [`SFPP_WORD_W-1:0] cmd_wdata,
   output logic rsp_valid,
   output logic [`SFPP_WORD_W-1:0] rsp_data
);
   import sfpp_pkg::*;

   ////////////////////////////////////////////////////////////////
   sfpp_host_s q, n;
   logic dat_s, tick;

   sfpp_sync #(.W(1)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(lnk.dat),
      .q(dat_s),
      .q_prev()
   );
   assign tick = (q.cnt == 24'h000000);

   always_comb begin
      n = q;
      n.rsp_valid = 1'b0;
      if (!tick) begin
         n.cnt = q.cnt - 24'h000001;
      end
      case (q.st)
         H_OFF: begin
            n.sck = 1'b0;
            n.dat_oe = 1'b1;
            n.dat_o = 1'b0;
            if (mode_en) begin
               n.master_clear_pin = 1'b1;
               n.cnt = 24'(`SFPP_T_HOLD_CYC - 1);
               n.st = H_HOLD;
            end
         end
         H_HOLD, H_WAIT: begin
            if (tick) begin
               n.st = H_IDLE;
            end
         end
         H_IDLE: begin
            if (!mode_en) begin
               n.master_clear_pin = 1'b0;
               n.st = H_OFF;
            end else if (cmd_valid) begin
               n.cmd = cmd_code;
               n.wd = cmd_wdata;
               n.sh = {12'h000, cmd_code};
               n.bitn = 5'h00;
               n.cnt = 24'(HALF_CYC - 1);
               n.st = H_CMD;
            end
         end
         H_GAP: begin
            if (tick) begin
               // start bit, twelve data bits, two ignored bits, stop bit
               n.sh = {3'b000, q.wd, 1'b0};
               n.dat_oe = (q.cmd == `SFPP_C_LOAD);
               n.bitn = 5'h00;
               n.cnt = 24'(HALF_CYC - 1);
               n.st = H_DATA;
            end
         end
         H_CMD, H_DATA: begin
            if (tick) begin
               n.cnt = 24'(HALF_CYC - 1);
               if (!q.sck) begin
                  n.sck = 1'b1;
                  n.dat_o = q.sh[0];
                  n.sh = {1'b0, q.sh[15:1]};
               end else begin
                  n.sck = 1'b0;
                  n.bitn = q.bitn + 5'h01;
                  if (q.st == H_DATA && q.bitn != 5'h00 && q.bitn < `SFPP_FRAME_BITS - 5'h01) begin
                     n.rd = {dat_s, q.rd[`SFPP_DATA_BITS-1:1]};
                  end
                  if (q.st == H_CMD && q.bitn == `SFPP_CMD_BITS - 5'h01) begin
                     if (q.cmd == `SFPP_C_LOAD || q.cmd == `SFPP_C_READ) begin
                        n.cnt = 24'(`SFPP_T_DLY_CYC - 1);
                        n.st = H_GAP;
                     end else begin
                        n.st = H_WAIT;
                        if (q.cmd == `SFPP_C_END) begin
                           n.cnt = 24'(T_END_CYC - 1);
                        end else if (q.cmd == `SFPP_C_ERASE) begin
                           n.cnt = 24'(T_ERA_CYC - 1);
                        end else begin
                           n.cnt = 24'(`SFPP_T_DLY_CYC - 1);
                        end
                     end
                  end
                  if (q.st == H_DATA && q.bitn == `SFPP_FRAME_BITS - 5'h01) begin
                     n.dat_oe = 1'b1;
                     n.dat_o = 1'b0;
                     n.rsp_valid = (q.cmd == `SFPP_C_READ);
                     n.rsp_data = q.rd[`SFPP_WORD_W-1:0];
                     n.cnt = 24'(`SFPP_T_DLY_CYC - 1);
                     n.st = H_WAIT;
                  end
               end
            end
         end
         default: begin
            n.st = H_OFF;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign lnk.sck = q.sck;
   assign lnk.master_clear_pin_hv = q.master_clear_pin;
   assign lnk.h_dat_o = q.dat_o;
   assign lnk.h_dat_oe = q.dat_oe;
   assign link_idle = (q.st == H_IDLE);
   assign cmd_ready = (q.st == H_IDLE) && mode_en;
   assign rsp_valid = q.rsp_valid;
   assign rsp_data = q.rsp_data;
endmodule // sfpp_prog
`default_nettype wire

// *** src/sfpp_sync.sv ***
// two-flop synchroniser with a third stage for edge detection
`default_nettype none
module sfpp_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q,
   output logic [W-1:0] q_prev
);
   logic [W-1:0] s1_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_q <= '0;
         q <= '0;
         q_prev <= '0;
      end else begin
         s1_q <= d;
         q <= s1_q;
         q_prev <= q;
      end
   end
endmodule // sfpp_sync
`default_nettype wire
